// ==== rtl/poc_defines.svh ====
`ifndef POC_DEFINES_SVH
`define POC_DEFINES_SVH

// Clock, divider tick, power-up and EEPROM write timing
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 2500
`define BOOT_DELAY_NS 3500000
`define EE_WRITE_CYCLES_DEF 1000

// Deassertion timeouts, codes 0 to 7
`define TMO_NS_0 25000
`define TMO_NS_1 1562500
`define TMO_NS_2 6250000
`define TMO_NS_3 25000000
`define TMO_NS_4 50000000
`define TMO_NS_5 200000000
`define TMO_NS_6 400000000
`define TMO_NS_7 1600000000

// Configuration space and serial commands
`define CFG_DEPTH 70
`define CFG_LAST 8'h45
`define EE_MIRROR_BASE 16'h8000
`define CMD_EE_PTR 8'h80
`define CMD_REBOOT 8'h88
`define SLAVE_ID 4'ha
`define BYTE_BITS 4'h8

// Register offsets
`define OFS_TMO1 8'h11
`define OFS_TMO2 8'h15
`define OFS_TMO3 8'h1c
`define OFS_TMO4 8'h23
`define OFS_TMO5 8'h2a
`define OFS_TMO6 8'h31
`define OFS_TMO7 8'h35
`define OFS_DEP_MON 8'h36
`define OFS_DEP_IN 8'h37
`define OFS_DEP_OUT 8'h38
`define OFS_DEP_TMO 8'h39
`define OFS_POLARITY 8'h3a
`define OFS_DEP_MRST 8'h40

// Field positions
`define TMO_LSB_A 1
`define TMO_LSB_B 2
`define BIT_DEP_WDOG 6
`define BIT_DEP_MRST 7
`define BIT_DEP_OUT7 0

// Factory image
`define EE_FACTORY 8'h00
`define POLARITY_FACTORY 8'hff

`endif

// ==== rtl/poc_pkg.sv ====
`include "poc_defines.svh"

package poc_pkg;
	typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_TXACK} bus_phase_t;
	typedef enum logic [1:0] {BOOT_COPY, BOOT_WAIT, BOOT_RUN} boot_phase_t;
	typedef logic [`CFG_DEPTH-1:0][7:0] cfg_image_t;

	typedef struct packed {
		logic active;
		logic [19:0] count;
	} timer_state_t;

	typedef struct packed {
		logic [7:0] sense;
		logic [1:0] addr;
		logic mrN;
		logic [3:0] gen;
		logic sda;
		logic scl;
	} pin_bundle_t;

	typedef struct packed {
		bus_phase_t phase;
		boot_phase_t boot;
		logic [3:0] bitCnt;
		logic [1:0] byteIdx;
		logic rw;
		logic ackGiven;
		logic [7:0] shift;
		logic [7:0] cmd;
		logic [7:0] ptr;
		logic eeSel;
		logic sdaOe;
		logic rebootReq;
		logic sclPrev;
		logic sdaPrev;
		logic [15:0] tickCnt;
		logic [18:0] bootCnt;
		logic [18:0] eeCnt;
		logic [7:0] progOe;
		cfg_image_t regs;
		cfg_image_t ee;
	} cfg_state_t;
endpackage

// ==== rtl/pin_sync.sv ====
module pin_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t state_r;
	sync_state_t state_nxt;

	// Two flops; the first feeds only the second
	always_comb begin
		state_nxt.meta = pinIn;
		state_nxt.stable = state_r.meta;
		if (rst) begin
			state_nxt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		state_r <= state_nxt;
	end

	assign pinOut = state_r.stable;
endmodule

// ==== rtl/deassert_timer.sv ====
`include "poc_defines.svh"

module deassert_timer #(
	parameter int TICK_NS = `TICK_PERIOD_NS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic hold,
	input wire logic [2:0] code,
	output logic active
);
	localparam logic [19:0] TMO_TICKS [8] = '{
		20'(`TMO_NS_0 / TICK_NS), 20'(`TMO_NS_1 / TICK_NS),
		20'(`TMO_NS_2 / TICK_NS), 20'(`TMO_NS_3 / TICK_NS),
		20'(`TMO_NS_4 / TICK_NS), 20'(`TMO_NS_5 / TICK_NS),
		20'(`TMO_NS_6 / TICK_NS), 20'(`TMO_NS_7 / TICK_NS)};

	poc_pkg::timer_state_t state_r;
	poc_pkg::timer_state_t state_nxt;

	// Assert at once, release a full timeout after the condition clears
	always_comb begin
		state_nxt = state_r;
		if (hold) begin
			state_nxt.active = 1'b1;
			state_nxt.count = TMO_TICKS[code];
		end else if (state_r.active && tick) begin
			if (state_r.count == '0) begin
				state_nxt.active = 1'b0;
			end else begin
				state_nxt.count = state_r.count - 20'h00001;
			end
		end
		if (rst) begin
			state_nxt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		state_r <= state_nxt;
	end

	assign active = state_r.active;
endmodule

// ==== rtl/programmable_output_config.sv ====
`include "poc_defines.svh"

// Notes on behaviour
// - Monitor dependency bits 5:0 tie output eight to monitor undervoltage one to six.
// - Monitor dependency bit 6 ties output eight to the watchdog condition.
// - Input bits 7:6 and output-dependency bits 1:0 tie it to general inputs one to four.
// - Output-dependency bits 7:2 and bit 0 at 39h tie it to outputs one to seven.
// - Manual-reset dependency bit 7 asserts output eight while manual reset is low.
// - A clear dependency bit makes output eight ignore that condition.
// - Polarity bit n covers output n+1; zero active low, one active high.
// - Outputs are open drain: pull low or release, never drive high.
// - Each output has a 3-bit timeout code selecting 25us up to 1600ms.
// - Factory image is all zero except polarity, which holds all ones.
// - EEPROM keeps the last written image across power loss, and across reset unless factoryLoad is set.
// - A send-byte of 88h reboots: EEPROM image is copied into the registers.
// - After reboot or power-up the same 3.5ms delay passes before operation.
// - During reboot or EEPROM write the slave address gets a not-acknowledge.
module programmable_output_config #(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int BOOT_DELAY_CYCLES = `BOOT_DELAY_NS / `CLK_PERIOD_NS,
	parameter int EE_WRITE_CYCLES = `EE_WRITE_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic factoryLoad,
	input wire logic [1:0] addrSel,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [5:0] uvFault,
	input wire logic watchdogFault,
	input wire logic [3:0] generalIn,
	input wire logic manualResetInN,
	input wire logic [6:0] assertReq,
	input wire logic [7:0] progOutSense,
	output logic [7:0] progOutDrive,
	output logic [7:0] progOutOe,
	output logic busy
);
	// Timeout register offsets and code positions per output
	localparam logic [7:0] TMO_OFS [8] = '{`OFS_TMO1, `OFS_TMO2, `OFS_TMO3, `OFS_TMO4,
		`OFS_TMO5, `OFS_TMO6, `OFS_TMO7, `OFS_DEP_TMO};
	localparam int TMO_LSB [8] = '{`TMO_LSB_A, `TMO_LSB_A, `TMO_LSB_B, `TMO_LSB_B,
		`TMO_LSB_A, `TMO_LSB_A, `TMO_LSB_A, `TMO_LSB_A};
	// Byte address of a register's EEPROM copy, for host software reference
	localparam logic [15:0] EE_BASE = `EE_MIRROR_BASE;

	poc_pkg::cfg_state_t state_r;
	poc_pkg::cfg_state_t state_nxt;
	poc_pkg::pin_bundle_t pins;
	logic [$bits(poc_pkg::pin_bundle_t)-1:0] pinsRaw;
	logic [$bits(poc_pkg::pin_bundle_t)-1:0] pinsSync;
	logic tick;
	logic [7:0] hold;
	logic [7:0] active;
	logic [7:0] outAsserted;
	logic [2:0] tmoCode [8];
	logic [7:0] depMon;
	logic [7:0] depIn;
	logic [7:0] depOut;
	logic [7:0] depTmo;
	logic [7:0] depMr;
	logic [7:0] polarity;

	// All pin inputs pass two flops before use
	assign pinsRaw = {progOutSense, addrSel, manualResetInN, generalIn, sdaIn, sclIn};

	pin_sync #(
		.W($bits(poc_pkg::pin_bundle_t))
	) pinSyncInst (
		.mclk(mclk),
		.rst(rst),
		.pinIn(pinsRaw),
		.pinOut(pinsSync)
	);

	assign pins = poc_pkg::pin_bundle_t'(pinsSync);

	// Configuration fields seen by the output logic
	assign depMon = state_r.regs[`OFS_DEP_MON];
	assign depIn = state_r.regs[`OFS_DEP_IN];
	assign depOut = state_r.regs[`OFS_DEP_OUT];
	assign depTmo = state_r.regs[`OFS_DEP_TMO];
	assign depMr = state_r.regs[`OFS_DEP_MRST];
	assign polarity = state_r.regs[`OFS_POLARITY];

	// Slow time base for the deassertion timers
	assign tick = (state_r.tickCnt == 16'(TICK_CYCLES - 1));

	// Present state of each output pin, taken through its polarity
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			outAsserted[i] = polarity[i] ? pins.sense[i] : ~pins.sense[i];
		end
	end

	// Output eight: OR of every enabled condition; clear mask bits drop out
	always_comb begin
		hold[6:0] = assertReq;
		hold[7] = (|(depMon[5:0] & uvFault))
			| (depMon[`BIT_DEP_WDOG] & watchdogFault)
			| (|({depOut[1:0], depIn[7:6]} & pins.gen))
			| (|({depTmo[`BIT_DEP_OUT7], depOut[7:2]} & outAsserted[6:0]))
			| (depMr[`BIT_DEP_MRST] & ~pins.mrN);
	end

	// Timeout code of each output from its own register
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			tmoCode[i] = 3'(state_r.regs[TMO_OFS[i]] >> TMO_LSB[i]);
		end
	end

	// One deassertion timer per output
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gTimer
			// Timeouts count nominal ticks, so a short divider cannot overflow the counter
			deassert_timer #(
				.TICK_NS(`TICK_PERIOD_NS)
			) timerInst (
				.mclk(mclk),
				.rst(rst),
				.tick(tick),
				.hold(hold[g]),
				.code(tmoCode[g]),
				.active(active[g])
			);
		end
	endgenerate

	// Main sequential behaviour: boot, EEPROM timing, serial slave
	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startSeen;
		logic stopSeen;
		logic ack;
		logic ptrOk;
		logic [7:0] rxByte;
		logic [7:0] rdByte;
		logic [6:0] idx;
		poc_pkg::cfg_image_t factory;

		sclRise = pins.scl & ~state_r.sclPrev;
		sclFall = ~pins.scl & state_r.sclPrev;
		startSeen = pins.scl & state_r.sclPrev & state_r.sdaPrev & ~pins.sda;
		stopSeen = pins.scl & state_r.sclPrev & ~state_r.sdaPrev & pins.sda;
		ack = 1'b0;
		rxByte = state_r.shift;
		idx = state_r.ptr[6:0];
		ptrOk = (state_r.ptr <= `CFG_LAST);
		rdByte = 8'h00;
		if (ptrOk) begin
			rdByte = state_r.eeSel ? state_r.ee[idx] : state_r.regs[idx];
		end
		factory = {`CFG_DEPTH{`EE_FACTORY}};
		factory[`OFS_POLARITY] = `POLARITY_FACTORY;

		state_nxt = state_r;
		state_nxt.sclPrev = pins.scl;
		state_nxt.sdaPrev = pins.sda;
		state_nxt.tickCnt = tick ? 16'h0000 : state_r.tickCnt + 16'h0001;

		// EEPROM write time; slave stays busy meanwhile
		if (state_r.eeCnt != '0) begin
			state_nxt.eeCnt = state_r.eeCnt - 19'h00001;
		end

		// Boot: copy EEPROM into the registers, then wait the power-up delay
		unique case (state_r.boot)
			poc_pkg::BOOT_COPY: begin
				state_nxt.regs = state_r.ee;
				state_nxt.bootCnt = '0;
				state_nxt.boot = poc_pkg::BOOT_WAIT;
			end
			poc_pkg::BOOT_WAIT: begin
				if (state_r.bootCnt == 19'(BOOT_DELAY_CYCLES - 1)) begin
					state_nxt.boot = poc_pkg::BOOT_RUN;
				end else begin
					state_nxt.bootCnt = state_r.bootCnt + 19'h00001;
				end
			end
			poc_pkg::BOOT_RUN: begin
			end
		endcase

		// Serial slave: start and stop override any phase
		if (startSeen) begin
			state_nxt.phase = poc_pkg::BUS_RX;
			state_nxt.bitCnt = '0;
			state_nxt.byteIdx = '0;
			state_nxt.sdaOe = 1'b0;
			state_nxt.rebootReq = 1'b0;
		end else if (stopSeen) begin
			if (state_r.rebootReq) begin
				state_nxt.boot = poc_pkg::BOOT_COPY;
			end
			state_nxt.phase = poc_pkg::BUS_IDLE;
			state_nxt.sdaOe = 1'b0;
			state_nxt.rebootReq = 1'b0;
		end else begin
			unique case (state_r.phase)
				poc_pkg::BUS_IDLE: begin
				end
				// Shift in eight bits, then judge the byte on the falling edge
				poc_pkg::BUS_RX: begin
					if (sclRise && state_r.bitCnt != `BYTE_BITS) begin
						state_nxt.shift = {state_r.shift[6:0], pins.sda};
						state_nxt.bitCnt = state_r.bitCnt + 4'h1;
					end else if (sclFall && state_r.bitCnt == `BYTE_BITS) begin
						unique case (state_r.byteIdx)
							2'h0: begin
								ack = (rxByte[7:4] == `SLAVE_ID) && (rxByte[3:2] == pins.addr)
									&& !busy;
								state_nxt.rw = rxByte[0];
							end
							2'h1: begin
								state_nxt.cmd = rxByte;
								state_nxt.rebootReq = (rxByte == `CMD_REBOOT);
								ack = (rxByte <= `CFG_LAST) || (rxByte == `CMD_EE_PTR)
									|| (rxByte == `CMD_REBOOT);
								if (rxByte <= `CFG_LAST) begin
									state_nxt.ptr = rxByte;
									state_nxt.eeSel = 1'b0;
								end
							end
							default: begin
								state_nxt.rebootReq = 1'b0;
								if (state_r.cmd <= `CFG_LAST) begin
									// Register write, word writes advance
									ack = ptrOk;
									if (ptrOk) begin
										state_nxt.regs[idx] = rxByte;
										state_nxt.ptr = state_r.ptr + 8'h01;
									end
								end else if (state_r.cmd == `CMD_EE_PTR
									&& state_r.byteIdx == 2'h2) begin
									// EEPROM pointer preset
									ack = (rxByte <= `CFG_LAST);
									if (ack) begin
										state_nxt.ptr = rxByte;
										state_nxt.eeSel = 1'b1;
									end
								end else if (state_r.cmd == `CMD_EE_PTR) begin
									// EEPROM byte write, refused until the previous write time ends
									ack = ptrOk && (state_r.eeCnt == '0);
									if (ack) begin
										state_nxt.ee[idx] = rxByte;
										state_nxt.eeCnt = 19'(EE_WRITE_CYCLES);
									end
								end
							end
						endcase
						state_nxt.byteIdx = (state_r.byteIdx == 2'h3) ? 2'h3
							: state_r.byteIdx + 2'h1;
						state_nxt.ackGiven = ack;
						state_nxt.sdaOe = ack;
						state_nxt.phase = poc_pkg::BUS_ACK;
					end
				end
				// End of acknowledge slot: go on receiving or start sending
				poc_pkg::BUS_ACK: begin
					if (sclFall) begin
						state_nxt.sdaOe = 1'b0;
						state_nxt.bitCnt = '0;
						if (!state_r.ackGiven) begin
							state_nxt.phase = poc_pkg::BUS_IDLE;
						end else if (state_r.rw) begin
							state_nxt.shift = rdByte;
							state_nxt.sdaOe = ~rdByte[7];
							state_nxt.phase = poc_pkg::BUS_TX;
						end else begin
							state_nxt.phase = poc_pkg::BUS_RX;
						end
					end
				end
				// Send a byte, most significant bit first
				poc_pkg::BUS_TX: begin
					if (sclFall) begin
						if (state_r.bitCnt == `BYTE_BITS - 4'h1) begin
							state_nxt.sdaOe = 1'b0;
							state_nxt.phase = poc_pkg::BUS_TXACK;
						end else begin
							state_nxt.shift = {state_r.shift[6:0], 1'b0};
							state_nxt.sdaOe = ~state_r.shift[6];
							state_nxt.bitCnt = state_r.bitCnt + 4'h1;
						end
					end
				end
				// Master acknowledge continues a word read, a NACK ends it
				poc_pkg::BUS_TXACK: begin
					if (sclRise) begin
						if (pins.sda) begin
							state_nxt.phase = poc_pkg::BUS_IDLE;
						end else begin
							state_nxt.ptr = state_r.ptr + 8'h01;
							state_nxt.ackGiven = 1'b1;
							state_nxt.phase = poc_pkg::BUS_ACK;
						end
					end
				end
				default: begin
					state_nxt.phase = poc_pkg::BUS_IDLE;
				end
			endcase
		end

		// Open-drain outputs, released until boot ends
		for (int i = 0; i < 8; i++) begin
			state_nxt.progOe[i] = (state_r.boot == poc_pkg::BOOT_RUN)
				&& (polarity[i] ? ~active[i] : active[i]);
		end

		// Reset keeps the EEPROM unless the factory image is requested
		if (rst) begin
			state_nxt = '0;
			state_nxt.phase = poc_pkg::BUS_IDLE;
			state_nxt.boot = poc_pkg::BOOT_COPY;
			state_nxt.sclPrev = 1'b1;
			state_nxt.sdaPrev = 1'b1;
			state_nxt.ee = factoryLoad ? factory : state_r.ee;
		end
	end

	always_ff @(posedge mclk) begin
		state_r <= state_nxt;
	end

	// Pins only ever pull low
	assign progOutDrive = 8'h00;
	assign progOutOe = state_r.progOe;
	assign sdaOut = 1'b0;
	assign sdaOe = state_r.sdaOe;
	assign busy = (state_r.boot != poc_pkg::BOOT_RUN) || (state_r.eeCnt != '0);
endmodule

// ==== verif/programmable_output_config_properties.sv ====
module programmable_output_config_properties #(
	parameter int BOOT_DELAY_CYCLES = 350000
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [7:0] progOutDrive,
	input wire logic [7:0] progOutOe,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed_r;
	int bootCnt_r;
	default clocking cb @(posedge mclk);
	endclocking
	// Counts the busy cycles of the boot that follows each reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			armed_r <= 1'b1;
			bootCnt_r <= 0;
		end else if (armed_r && busy) begin
			bootCnt_r <= bootCnt_r + 1;
		end else begin
			armed_r <= 1'b0;
		end
	end
	AST_DRIVE_LOW: assert property (progOutDrive == 8'h00)
		else $error("output pin driven high");
	AST_SDA_LOW: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	AST_RST_FREE: assert property (rst |=> progOutOe == 8'h00 && !sdaOe)
		else $error("pins pulled during reset");
	AST_RST_BUSY: assert property (rst |=> busy)
		else $error("busy low during reset");
	AST_BOOT_BUSY: assert property (disable iff (rst) $fell(rst) |-> busy [*8])
		else $error("busy dropped early in boot");
	AST_BOOT_IDLE: assert property (disable iff (rst) $fell(rst) |-> (progOutOe == 8'h00) [*8])
		else $error("outputs pulled during boot");
	AST_BOOT_MIN: assert property (disable iff (rst) armed_r && !busy |-> bootCnt_r >= BOOT_DELAY_CYCLES)
		else $error("boot delay too short");
	AST_BOOT_MAX: assert property (disable iff (rst) armed_r |-> bootCnt_r <= BOOT_DELAY_CYCLES + 4)
		else $error("boot delay too long");
	AST_ACK_SCL_LOW: assert property (disable iff (rst) $changed(sdaOe) |-> !sclIn)
		else $error("data pin moved while clock high");
	// Main scenarios seen
	cover property (disable iff (rst) $fell(busy));
	cover property (disable iff (rst) $rose(sdaOe));
	cover property (disable iff (rst) $fell(progOutOe[7]));
endmodule

bind programmable_output_config programmable_output_config_properties #(
	.BOOT_DELAY_CYCLES(BOOT_DELAY_CYCLES)
) u_props (
	.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.progOutDrive(progOutDrive), .progOutOe(progOutOe), .busy(busy)
);

// ==== verif/supply_line_model.sv ====
module supply_line_model (
	input wire logic [7:0] progOutOe,
	input wire logic [7:0] progOutDrive,
	input wire logic sdaOe,
	input wire logic sdaOut,
	input wire logic masterSdaLow,
	output logic [7:0] progOutSense,
	output logic sdaLine
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-ups: a released line reads high, an enabled driver sets it
	assign progOutSense = ~progOutOe | (progOutOe & progOutDrive);
	assign sdaLine = ~(sdaOe & ~sdaOut) & ~masterSdaLow;
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BOOT = 300;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic factoryLoad = 1'b1;
	logic sclIn = 1'b1;
	logic masterSdaLow = 1'b0;
	logic [18:0] cond = '0;
	logic sdaLine, sdaOut, sdaOe, busy;
	logic [7:0] progOutSense, progOutDrive, progOutOe;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	// Clock and cycle count
	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	programmable_output_config #(
		.TICK_CYCLES(2), .BOOT_DELAY_CYCLES(BOOT), .EE_WRITE_CYCLES(400)
	) u_programmable_output_config (
		.mclk(mclk), .rst(rst), .factoryLoad(factoryLoad), .addrSel(2'h1),
		.sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.uvFault(cond[5:0]), .watchdogFault(cond[6]), .generalIn(cond[10:7]),
		.manualResetInN(~cond[18]), .assertReq(cond[17:11]),
		.progOutSense(progOutSense), .progOutDrive(progOutDrive),
		.progOutOe(progOutOe), .busy(busy)
	);
	supply_line_model u_supply_line_model (
		.progOutOe(progOutOe), .progOutDrive(progOutDrive), .sdaOe(sdaOe),
		.sdaOut(sdaOut), .masterSdaLow(masterSdaLow), .progOutSense(progOutSense),
		.sdaLine(sdaLine)
	);

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bus start and stop, both with the data edge while the clock is high
	task automatic start_c;
		masterSdaLow = 1'b0;
		hold(6);
		sclIn = 1'b1;
		hold(8);
		masterSdaLow = 1'b1;
		hold(8);
		sclIn = 1'b0;
		hold(4);
	endtask
	task automatic stop_c;
		masterSdaLow = 1'b1;
		hold(6);
		sclIn = 1'b1;
		hold(8);
		masterSdaLow = 1'b0;
		hold(8);
	endtask
	// Nine clocks: data changes only while the clock is low
	task automatic bx(input logic [8:0] v, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			masterSdaLow = !v[i];
			hold(6);
			sclIn = 1'b1;
			hold(8);
			r[i] = sdaLine;
			sclIn = 1'b0;
			hold(4);
		end
	endtask
	task automatic sb(input logic [7:0] b, input logic ack);
		logic [8:0] r;
		bx({b, 1'b1}, r);
		chk("ack", {7'h00, ack}, {7'h00, !r[0]});
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		start_c;
		sb(8'ha4, 1'b1);
		sb(a, 1'b1);
		sb(d, 1'b1);
		stop_c;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		logic [8:0] r;
		start_c;
		sb(8'ha4, 1'b1);
		sb(a, 1'b1);
		start_c;
		sb(8'ha5, 1'b1);
		bx(9'h1ff, r);
		stop_c;
		chk("register", exp, r[8:1]);
	endtask
	task automatic wait_idle;
		for (int n = 0; n < 3000 && busy !== 1'b0; n++)
			hold(1);
		chk("busy", 8'h00, {7'h00, busy});
	endtask
	task automatic do_reset(input logic fl);
		rst = 1'b1;
		factoryLoad = fl;
		hold(8);
		rst = 1'b0;
		wait_idle;
	endtask
	// Register address and bit mask selecting each condition
	function automatic logic [15:0] dep_of(input int k);
		if (k < 7)
			return {8'h36, 8'h01 << k};
		if (k < 9)
			return {8'h37, 8'h40 << (k - 7)};
		if (k < 17)
			return {8'h38, 8'h01 << (k - 9)};
		if (k == 17)
			return {8'h39, 8'h01};
		return {8'h40, 8'h80};
	endfunction

	task automatic t_factory;
		rreg(8'h36, 8'h00);
		rreg(8'h39, 8'h00);
		rreg(8'h3a, 8'hff);
	endtask
	// Each condition enabled alone, the others acting as distractors
	task automatic t_deps;
		logic [15:0] d;
		for (int k = 0; k < 19; k++) begin
			d = dep_of(k);
			wreg(d[15:8], d[7:0]);
			cond = ~(19'h1 << k);
			hold(16);
			chk("ignored", 8'h01, {7'h00, progOutOe[7]});
			cond = '1;
			hold(16);
			chk("asserted", 8'h00, {7'h00, progOutOe[7]});
			cond = '0;
			hold(80);
			chk("released", 8'h01, {7'h00, progOutOe[7]});
			wreg(d[15:8], 8'h00);
		end
	endtask
	// Polarity swap, then the 1.5625ms release delay
	task automatic t_pol;
		wreg(8'h40, 8'h80);
		wreg(8'h39, 8'h02);
		cond = 19'h40000;
		hold(16);
		chk("active high", 8'h00, {7'h00, progOutOe[7]});
		wreg(8'h3a, 8'h7f);
		chk("active low", 8'h01, {7'h00, progOutOe[7]});
		cond = '0;
		hold(1200);
		chk("held", 8'h01, {7'h00, progOutOe[7]});
		hold(100);
		chk("freed", 8'h00, {7'h00, progOutOe[7]});
		wreg(8'h3a, 8'hff);
		wreg(8'h40, 8'h00);
		wreg(8'h39, 8'h00);
	endtask
	// EEPROM write, refusals while busy, reboot and retention
	task automatic t_eeprom;
		int t0;
		logic [8:0] r;
		wreg(8'h3a, 8'h5a);
		rreg(8'h3a, 8'h5a);
		start_c;
		sb(8'ha4, 1'b1);
		sb(8'h80, 1'b1);
		sb(8'h3a, 1'b1);
		sb(8'hc3, 1'b1);
		stop_c;
		start_c;
		sb(8'ha4, 1'b0);
		stop_c;
		wait_idle;
		start_c;
		sb(8'ha4, 1'b1);
		sb(8'h80, 1'b1);
		sb(8'h3a, 1'b1);
		start_c;
		sb(8'ha5, 1'b1);
		bx(9'h1ff, r);
		stop_c;
		chk("eeprom", 8'hc3, r[8:1]);
		rreg(8'h3a, 8'h5a);
		start_c;
		sb(8'ha4, 1'b1);
		sb(8'h88, 1'b1);
		t0 = cyc;
		stop_c;
		start_c;
		sb(8'ha4, 1'b0);
		stop_c;
		wait_idle;
		chk("boot", 8'h01, {7'h00, cyc - t0 > BOOT && cyc - t0 < BOOT + 30});
		rreg(8'h3a, 8'hc3);
		do_reset(1'b0);
		rreg(8'h3a, 8'hc3);
		start_c;
		sb(8'ha4, 1'b1);
		sb(8'h80, 1'b1);
		sb(8'h3a, 1'b1);
		sb(8'h00, 1'b1);
		stop_c;
		wait_idle;
		do_reset(1'b0);
		rreg(8'h3a, 8'h00);
		do_reset(1'b1);
		rreg(8'h3a, 8'hff);
	endtask

	initial begin
		do_reset(1'b1);
		t_factory;
		t_deps;
		t_pol;
		t_eeprom;
		close_out;
	end
	// Cuts a hung run short
	initial begin
		hold(90000);
		errors++;
		close_out;
	end
endmodule
